// ===== include/flag_decode_defs.svh
// Opcode, flag position and timing constants for the branch and flag decoder.
`ifndef FLAG_DECODE_DEFS_SVH
`define FLAG_DECODE_DEFS_SVH
`define OP_BR_HIGHER     8'h22
`define OP_BR_LOWER_SAME 8'h23
`define OP_BR_CARRY_CLR  8'h24
`define OP_BR_NOT_EQUAL  8'h26
`define OP_BR_EQUAL      8'h27
`define OP_BR_OVF_CLR    8'h28
`define OP_BR_OVF_SET    8'h29
`define OP_FLAGS_FROM_A  8'h06
`define OP_FLAGS_TO_A    8'h07
`define OP_CLR_OVF       8'h0A
`define OP_SET_OVF       8'h0B
`define OP_CLR_CARRY     8'h0C
`define OP_SET_CARRY     8'h0D
`define OP_CLR_IRQ       8'h0E
`define OP_SET_IRQ       8'h0F
`define FLAG_C 0
`define FLAG_V 1
`define FLAG_Z 2
`define FLAG_N 3
`define FLAG_I 4
`define FLAG_H 5
`define FLAGS_RESET      6'h10
`define BRANCH_CYCLES    2'h3
`define BRANCH_BYTES     2'h2
`define FLAG_OP_CYCLES   2'h2
`define FLAG_OP_BYTES    2'h1
`endif

// ===== include/flag_decode_pkg.sv
// Types shared by the branch and flag decoder.
package flag_decode_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_DONE = 3'b100
  } exec_state_t;
endpackage

// ===== verilog/branch_test.sv
`timescale 1ns/1ps
// Combinational branch condition evaluation from opcode and flags.
`include "flag_decode_defs.svh"
module branch_test
  import flag_decode_pkg::*;
(
  input  wire logic [7:0] opcode_i,
  input  wire logic [5:0] flags_i,
  output logic            is_branch_o,
  output logic            taken_o
);
  // Each supported branch opcode maps to one test of the flags.
  always_comb begin
    is_branch_o = 1'b1;
    taken_o     = 1'b0;
    case (opcode_i)
      `OP_BR_CARRY_CLR:  taken_o = ~flags_i[`FLAG_C];
      `OP_BR_LOWER_SAME: taken_o = flags_i[`FLAG_C] | flags_i[`FLAG_Z];
      `OP_BR_HIGHER:     taken_o = ~(flags_i[`FLAG_C] | flags_i[`FLAG_Z]);
      `OP_BR_NOT_EQUAL:  taken_o = ~flags_i[`FLAG_Z];
      `OP_BR_EQUAL:      taken_o = flags_i[`FLAG_Z];
      `OP_BR_OVF_CLR:    taken_o = ~flags_i[`FLAG_V];
      `OP_BR_OVF_SET:    taken_o = flags_i[`FLAG_V];
      default:           is_branch_o = 1'b0;
    endcase
  end
endmodule

// ===== verilog/branch_and_flag_instr_decode.sv
`timescale 1ns/1ps
// Decode and execute of relative branches and flag manipulation instructions.
`include "flag_decode_defs.svh"
module branch_and_flag_instr_decode
  import flag_decode_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        instr_valid_i,
  input  wire logic [7:0]  opcode_i,
  input  wire logic [7:0]  displacement_i,
  input  wire logic [15:0] opcode_addr_i,
  input  wire logic [7:0]  acc_a_i,
  output logic             instr_ready_o,
  output logic             supported_o,
  output logic             done_o,
  output logic [15:0]      next_pc_o,
  output logic             branch_taken_o,
  output logic [1:0]       instr_bytes_o,
  output logic             acc_a_write_o,
  output logic [7:0]       acc_a_data_o,
  output logic [5:0]       condition_flags_o
);
  exec_state_t state_reg;
  logic [5:0]  condition_flags_reg;
  logic [1:0]  cycle_reg;
  logic [7:0]  op_reg;
  logic [7:0]  disp_reg;
  logic [15:0] addr_reg;
  logic [7:0]  acc_reg;
  logic        is_branch;
  logic        taken;
  logic        is_flag_op;
  logic [1:0]  cycles_needed;

  branch_test u_test (
    .opcode_i    (op_reg),
    .flags_i     (condition_flags_reg),
    .is_branch_o (is_branch),
    .taken_o     (taken)
  );

  // Flag opcodes are recognised by table so that others are refused.
  function automatic logic flag_op(input logic [7:0] op);
    case (op)
      `OP_CLR_CARRY, `OP_SET_CARRY, `OP_CLR_IRQ, `OP_SET_IRQ,
      `OP_CLR_OVF, `OP_SET_OVF, `OP_FLAGS_FROM_A, `OP_FLAGS_TO_A: flag_op = 1'b1;
      default: flag_op = 1'b0;
    endcase
  endfunction

  function automatic logic branch_op(input logic [7:0] op);
    branch_op = (op == `OP_BR_HIGHER) || (op == `OP_BR_LOWER_SAME) || (op == `OP_BR_CARRY_CLR) ||
                (op == `OP_BR_NOT_EQUAL) || (op == `OP_BR_EQUAL) || (op == `OP_BR_OVF_CLR) ||
                (op == `OP_BR_OVF_SET);
  endfunction

  assign is_flag_op    = flag_op(op_reg);
  assign cycles_needed = is_branch ? `BRANCH_CYCLES : `FLAG_OP_CYCLES;
  assign instr_ready_o = (state_reg == ST_IDLE);
  assign supported_o   = branch_op(opcode_i) | flag_op(opcode_i);
  assign condition_flags_o = condition_flags_reg;

  // Sequencer: one cycle per machine cycle; the last cycle retires the instruction.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_IDLE;
      cycle_reg <= 2'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (instr_valid_i && supported_o) begin
            state_reg <= ST_BUSY;
            cycle_reg <= 2'h1;
          end
        end
        ST_BUSY: begin
          if (cycle_reg == cycles_needed - 2'h1) begin
            state_reg <= ST_DONE;
          end
          cycle_reg <= cycle_reg + 2'h1;
        end
        ST_DONE: begin
          state_reg <= ST_IDLE;
          cycle_reg <= 2'h0;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Instruction capture happens when accepted so the operands stay stable.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      op_reg   <= 8'h01;
      disp_reg <= 8'h00;
      addr_reg <= 16'h0000;
      acc_reg  <= 8'h00;
    end else if (instr_ready_o && instr_valid_i && supported_o) begin
      op_reg   <= opcode_i;
      disp_reg <= displacement_i;
      addr_reg <= opcode_addr_i;
      acc_reg  <= acc_a_i;
    end
  end

  // Flags change only at retirement; branches never touch them.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      condition_flags_reg <= `FLAGS_RESET;
    end else if (state_reg == ST_DONE) begin
      case (op_reg)
        `OP_CLR_CARRY:    condition_flags_reg[`FLAG_C] <= 1'b0;
        `OP_SET_CARRY:    condition_flags_reg[`FLAG_C] <= 1'b1;
        `OP_CLR_IRQ:      condition_flags_reg[`FLAG_I] <= 1'b0;
        `OP_SET_IRQ:      condition_flags_reg[`FLAG_I] <= 1'b1;
        `OP_CLR_OVF:      condition_flags_reg[`FLAG_V] <= 1'b0;
        `OP_SET_OVF:      condition_flags_reg[`FLAG_V] <= 1'b1;
        `OP_FLAGS_FROM_A: condition_flags_reg <= acc_reg[5:0];
        default:          condition_flags_reg <= condition_flags_reg;
      endcase
    end
  end

  // Results are registered at retirement and shown with done_o.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      done_o         <= 1'b0;
      next_pc_o      <= 16'h0000;
      branch_taken_o <= 1'b0;
      instr_bytes_o  <= 2'h0;
      acc_a_write_o  <= 1'b0;
      acc_a_data_o   <= 8'h00;
    end else begin
      done_o        <= (state_reg == ST_DONE);
      acc_a_write_o <= (state_reg == ST_DONE) && (op_reg == `OP_FLAGS_TO_A);
      if (state_reg == ST_DONE) begin
        instr_bytes_o  <= is_branch ? `BRANCH_BYTES : `FLAG_OP_BYTES;
        branch_taken_o <= is_branch && taken;
        if (is_branch && taken) begin
          next_pc_o <= addr_reg + {14'h0000, `BRANCH_BYTES} + {{8{disp_reg[7]}}, disp_reg};
        end else begin
          next_pc_o <= addr_reg + {14'h0000, (is_branch ? `BRANCH_BYTES : `FLAG_OP_BYTES)};
        end
        // Upper two bits read as one, as unused flag positions do.
        acc_a_data_o <= {2'b11, condition_flags_reg};
      end
    end
  end

  // A retired instruction spent exactly its documented cycle count.
  a_exec_cycles: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (state_reg == ST_DONE) |-> (cycle_reg == cycles_needed))
    else $error("instruction cycle count wrong");

  a_branch_flags: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (state_reg == ST_DONE && is_branch) |=> $stable(condition_flags_reg))
    else $error("branch changed flags");

  a_carry_clear: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (state_reg == ST_DONE && op_reg == `OP_CLR_CARRY) |=> !condition_flags_reg[`FLAG_C])
    else $error("carry not cleared");

  a_carry_branch: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (state_reg == ST_DONE && op_reg == `OP_BR_CARRY_CLR) |=> (branch_taken_o == !$past(condition_flags_reg[`FLAG_C])))
    else $error("carry clear branch wrong");

  a_ovf_branch: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (state_reg == ST_DONE && op_reg == `OP_BR_OVF_SET) |=> (branch_taken_o == $past(condition_flags_reg[`FLAG_V])))
    else $error("overflow set branch wrong");

  a_ovf_clear: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (state_reg == ST_DONE && op_reg == `OP_BR_OVF_CLR) |=> (branch_taken_o != $past(condition_flags_reg[`FLAG_V])))
    else $error("overflow clear branch wrong");

  a_lower_same: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (state_reg == ST_DONE && op_reg == `OP_BR_LOWER_SAME) |=>
      (branch_taken_o == ($past(condition_flags_reg[`FLAG_C]) | $past(condition_flags_reg[`FLAG_Z]))))
    else $error("lower or same branch wrong");

  a_transfer_in: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (state_reg == ST_DONE && op_reg == `OP_FLAGS_FROM_A) |=> (condition_flags_reg == $past(acc_reg[5:0])))
    else $error("accumulator to flags wrong");

  a_untaken_pc: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (state_reg == ST_DONE && is_branch && !taken) |=> (next_pc_o == $past(addr_reg) + {14'h0000, `BRANCH_BYTES}))
    else $error("untaken branch address wrong");

  a_same_opcode: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (op_reg == `OP_BR_CARRY_CLR) |-> (is_branch && taken == !condition_flags_reg[`FLAG_C]))
    else $error("higher or same decode wrong");

  // The completion strobe must drop again, or the core would retire one instruction twice.
  a_done_pulse: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    done_o |=> !done_o)
    else $error("done pulse longer than one cycle");

  a_higher_branch: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (state_reg == ST_DONE && op_reg == `OP_BR_HIGHER) |=>
      (branch_taken_o == !($past(condition_flags_reg[`FLAG_C]) | $past(condition_flags_reg[`FLAG_Z]))))
    else $error("higher branch wrong");

  a_equal_branch: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (state_reg == ST_DONE && op_reg == `OP_BR_EQUAL) |=> (branch_taken_o == $past(condition_flags_reg[`FLAG_Z])))
    else $error("equal branch wrong");

  a_carry_set: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (state_reg == ST_DONE && op_reg == `OP_SET_CARRY) |=> condition_flags_reg[`FLAG_C])
    else $error("carry not set");

  // The copy to A must carry the flags as they stood before retirement.
  a_flags_to_acc: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (state_reg == ST_DONE && op_reg == `OP_FLAGS_TO_A) |=>
      (acc_a_write_o && acc_a_data_o[5:0] == $past(condition_flags_reg)))
    else $error("flags to accumulator wrong");
endmodule

// ===== tb/branch_and_flag_instr_decode_tb.sv
// Self-checking testbench for the branch and flag instruction decoder.
`timescale 1ns/1ps
module branch_and_flag_instr_decode_tb;
  logic        ref_clk_i      = 1'b0;
  logic        sys_rst_i      = 1'b1;
  logic        instr_valid_i  = 1'b0;
  logic [7:0]  opcode_i       = 8'h01;
  logic [7:0]  displacement_i = 8'h00;
  logic [15:0] opcode_addr_i  = 16'h0000;
  logic [7:0]  acc_a_i        = 8'h00;
  logic        instr_ready_o;
  logic        supported_o;
  logic        done_o;
  logic [15:0] next_pc_o;
  logic        branch_taken_o;
  logic [1:0]  instr_bytes_o;
  logic        acc_a_write_o;
  logic [7:0]  acc_a_data_o;
  logic [5:0]  condition_flags_o;
  logic [5:0]  ef             = 6'h10;
  int          fail_count     = 0;
  int          n_tests        = 0;

  branch_and_flag_instr_decode dut_u (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .instr_valid_i(instr_valid_i),
    .opcode_i(opcode_i), .displacement_i(displacement_i), .opcode_addr_i(opcode_addr_i), .acc_a_i(acc_a_i),
    .instr_ready_o(instr_ready_o), .supported_o(supported_o), .done_o(done_o), .next_pc_o(next_pc_o),
    .branch_taken_o(branch_taken_o), .instr_bytes_o(instr_bytes_o), .acc_a_write_o(acc_a_write_o),
    .acc_a_data_o(acc_a_data_o), .condition_flags_o(condition_flags_o));

  // The 20 MHz machine clock.
  always #25 ref_clk_i = ~ref_clk_i;

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (e !== g) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Branch outcome worked out independently from the flags before the instruction.
  function automatic logic tk(input logic [7:0] op, input logic [5:0] f);
    case (op)
      8'h24: tk = ~f[0];
      8'h23: tk = f[0] | f[2];
      8'h22: tk = ~(f[0] | f[2]);
      8'h26: tk = ~f[2];
      8'h27: tk = f[2];
      8'h28: tk = ~f[1];
      8'h29: tk = f[1];
      default: tk = 1'b0;
    endcase
  endfunction

  // One instruction, driven at falling edges and judged when done pulses.
  task automatic exec(input logic [7:0] op, input logic [7:0] d, input logic [15:0] a, input logic [7:0] acc);
    int         n;
    logic       br;
    logic [5:0] f;
    br = (op[7:4] == 4'h2);
    f = ef;
    @(negedge ref_clk_i);
    instr_valid_i = 1'b1;
    opcode_i = op;
    displacement_i = d;
    opcode_addr_i = a;
    acc_a_i = acc;
    #1;
    chk("supported", 16'h0001, {15'h0000, supported_o});
    @(negedge ref_clk_i);
    instr_valid_i = 1'b0;
    chk("ready", 16'h0000, {15'h0000, instr_ready_o});
    n = 0;
    // Bounded wait so that a missing done pulse cannot hang the run.
    while (done_o !== 1'b1 && n < 12) begin
      @(negedge ref_clk_i);
      n++;
    end
    case (op)
      8'h06: ef = acc[5:0];
      8'h0A: ef[1] = 1'b0;
      8'h0B: ef[1] = 1'b1;
      8'h0C: ef[0] = 1'b0;
      8'h0D: ef[0] = 1'b1;
      8'h0E: ef[4] = 1'b0;
      8'h0F: ef[4] = 1'b1;
      default: ;
    endcase
    chk("cycles", br ? 16'h0003 : 16'h0002, 16'(n));
    chk("bytes", br ? 16'h0002 : 16'h0001, {14'h0000, instr_bytes_o});
    chk("taken", {15'h0000, tk(op, f)}, {15'h0000, branch_taken_o});
    chk("next_pc", a + (br ? 16'h0002 : 16'h0001) + (tk(op, f) ? {{8{d[7]}}, d} : 16'h0000), next_pc_o);
    chk("flags", {10'h000, ef}, {10'h000, condition_flags_o});
    chk("acc_write", {15'h0000, op == 8'h07}, {15'h0000, acc_a_write_o});
    if (op == 8'h07) chk("acc_data", {8'h00, 2'h3, f}, {8'h00, acc_a_data_o});
    // Both strobes stand for one cycle only.
    @(negedge ref_clk_i);
    chk("done_drop", 16'h0000, {15'h0000, done_o});
    chk("acc_write_drop", 16'h0000, {15'h0000, acc_a_write_o});
  endtask

  task automatic t_reset;
    chk("reset_ready", 16'h0001, {15'h0000, instr_ready_o});
    chk("reset_done", 16'h0000, {15'h0000, done_o});
    chk("reset_flags", 16'h0010, {10'h000, condition_flags_o});
  endtask

  // Every branch against several flag patterns; negative and wrapping displacements.
  task automatic t_branch_table;
    logic [7:0] pats [5] = '{8'h00, 8'h01, 8'h04, 8'h02, 8'h3F};
    logic [7:0] ops [7] = '{8'h24, 8'h23, 8'h22, 8'h26, 8'h27, 8'h28, 8'h29};
    foreach (pats[i]) begin
      exec(8'h06, 8'h00, 16'h1000, pats[i]);
      foreach (ops[j]) exec(ops[j], j[0] ? 8'hF0 : 8'h7F, 16'hFFF0 + 16'(j), 8'hC3);
    end
  endtask

  // Clear then set the carry, overflow and interrupt flags, copying the flags back to A after each group.
  task automatic t_flag_ops;
    logic [7:0] seq [10] = '{8'h0C, 8'h0A, 8'h0E, 8'h07, 8'h0D, 8'h0B, 8'h0F, 8'h07, 8'h06, 8'h07};
    foreach (seq[i]) exec(seq[i], 8'h55, 16'h2000 + 16'(i), 8'hEA);
  endtask

  // An opcode outside the handled set is never taken and never answered.
  task automatic t_refused;
    @(negedge ref_clk_i);
    instr_valid_i = 1'b1;
    opcode_i = 8'h25;
    #1;
    chk("unsupported", 16'h0000, {15'h0000, supported_o});
    repeat (6) begin
      @(negedge ref_clk_i);
      chk("no_done", 16'h0000, {15'h0000, done_o});
      chk("no_accept", 16'h0001, {15'h0000, instr_ready_o});
    end
    instr_valid_i = 1'b0;
  endtask

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence; reset is held for three cycles before any request.
  initial begin
    repeat (3) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    t_reset();
    t_branch_table();
    t_flag_ops();
    t_refused();
    finish_test();
  end

  // Watchdog well beyond the few hundred cycles that the tests need.
  initial begin
    #200000;
    fail_count++;
    finish_test();
  end
endmodule
